// >>> sgc_object_ctrl.sv
`timescale 1ns/1ns
// What this block does
// - Eight objects, each with its own open and close command output.
// - Per-object failure output asserts when a requested control does not complete.
// - State decoded from open/close feedback: 00, open, close, 11.
// - Command is a pulse ending on state change or maximum length.
// - Timeout ends the command, sets failure, raises undefined-state event.
// - Completion timeout applies only to the ready indication.
// - Without ready feedback assigned, completion timeout is ignored.
// - Open and close control pulse signals emitted for every commanded object.
// - Remote inputs act only in remote state, local only in local.
// - Local state ignores remote inputs; remote state ignores local inputs.
// - Commands trigger on a rising edge of the command input only.
// - Local accepts panel and tool control; remote accepts protocol control.
// - Local/remote chosen by front panel or one digital input.
// - Setting changes accepted from tool and protocol in either mode.
// - Virtual inputs gated by local/remote unless a device option disables it.
// - Close and trip buttons act on configured object only with password.
// - Selective button mode needs select then confirm; direct acts immediately.
// - Function button may release latches with a configurable pulse length.
// - Release signal activates only while a latched output is active.
// - Panel release-all accepted only after a correct password.
// - Latched outputs stay on until the common release clears them all.
module sgc_object_ctrl
    import sgc_pkg::*;
#(
    parameter int unsigned N_OBJ = 8,
    parameter int unsigned TICK_DIV = TICK_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    input wire logic [N_OBJ-1:0] i_open_feedback_input,
    input wire logic [N_OBJ-1:0] i_close_feedback_input,
    input wire logic [N_OBJ-1:0] i_ready_feedback_input,
    input wire logic [N_OBJ-1:0] i_remote_open,
    input wire logic [N_OBJ-1:0] i_remote_close,
    input wire logic [N_OBJ-1:0] i_local_open,
    input wire logic [N_OBJ-1:0] i_local_close,
    input wire logic i_lr_input,
    input wire logic i_close_button,
    input wire logic i_trip_button,
    input wire logic i_function_button_one,
    input wire logic [N_OBJ-1:0] i_latch_set,
    output sgc_cmd_s [N_OBJ-1:0] o_cmd,
    output logic [N_OBJ-1:0] o_fail,
    output logic [N_OBJ-1:0] o_undef_event,
    output logic [N_OBJ-1:0] o_latched,
    output logic o_latch_release,
    output logic o_remote,
    output logic [N_OBJ-1:0] o_vi
);

    // ****************************************************************
    // Input synchronisers and edge detection
    // ****************************************************************
    localparam int unsigned SW = 7 * N_OBJ + 4;
    logic [SW-1:0] raw_in;
    logic [SW-1:0] s1_q, s2_q, s3_q;
    logic [SW-1:0] rise;
    assign raw_in = {i_open_feedback_input, i_close_feedback_input,
        i_ready_feedback_input, i_remote_open, i_remote_close,
        i_local_open, i_local_close, i_lr_input, i_close_button,
        i_trip_button, i_function_button_one};

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else begin
            s1_q <= raw_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end
    assign rise = s2_q & ~s3_q;

    logic [N_OBJ-1:0] fb_open, fb_close, fb_ready;
    logic [N_OBJ-1:0] re_ro, re_rc, re_lo, re_lc;
    logic lr_pin, rise_close_btn, rise_trip_btn, rise_fb1;
    assign fb_open = s2_q[SW-1 -: N_OBJ];
    assign fb_close = s2_q[SW-1-N_OBJ -: N_OBJ];
    assign fb_ready = s2_q[SW-1-2*N_OBJ -: N_OBJ];
    assign re_ro = rise[SW-1-3*N_OBJ -: N_OBJ];
    assign re_rc = rise[SW-1-4*N_OBJ -: N_OBJ];
    assign re_lo = rise[SW-1-5*N_OBJ -: N_OBJ];
    assign re_lc = rise[SW-1-6*N_OBJ -: N_OBJ];
    assign lr_pin = s2_q[3];
    assign rise_close_btn = rise[2];
    assign rise_trip_btn = rise[1];
    assign rise_fb1 = rise[0];

    // ****************************************************************
    // Timebase
    // ****************************************************************
    logic [23:0] div_q;
    logic tick;
    always_ff @(posedge i_clk) begin
        if (i_reset || tick) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + 24'h000001;
        end
    end
    assign tick = (div_q == 24'(TICK_DIV - 1));

    // ****************************************************************
    // Register bus
    // ****************************************************************
    logic [31:0] ctrl_q;
    logic [TIME_W-1:0] pulse_len_q, ready_to_q, release_len_q;
    logic [N_OBJ-1:0] ready_en_q;
    logic [31:0] panel_cmd, proto_cmd;
    logic remote_mode;
    logic [N_OBJ-1:0] vi_q;

    // Setting registers take writes regardless of mode
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            ctrl_q <= CTRL_RST;
            pulse_len_q <= PULSE_RST;
            ready_to_q <= READY_RST;
            release_len_q <= RELEASE_RST;
            ready_en_q <= '0;
        end else if (i_wr) begin
            if (i_addr == REG_CTRL) begin
                ctrl_q <= i_wdata;
            end else if (i_addr == REG_PULSE) begin
                pulse_len_q <= i_wdata[TIME_W-1:0];
            end else if (i_addr == REG_READY) begin
                ready_to_q <= i_wdata[TIME_W-1:0];
            end else if (i_addr == REG_RELEASE) begin
                release_len_q <= i_wdata[TIME_W-1:0];
            end else if (i_addr == REG_READY_EN) begin
                ready_en_q <= i_wdata[N_OBJ-1:0];
            end
        end
    end

    assign panel_cmd = (i_wr && i_addr == REG_PANEL_CMD) ? i_wdata : '0;
    assign proto_cmd = (i_wr && i_addr == REG_PROTO_CMD) ? i_wdata : '0;
    assign remote_mode = ctrl_q[CTRL_LR_SRC] ? lr_pin
                                             : ctrl_q[CTRL_PANEL_REMOTE];

    // ****************************************************************
    // Command sources
    // ****************************************************************
    logic [N_OBJ-1:0] sel_q;
    logic [N_OBJ-1:0] btn_obj;
    logic pass_ok, btn_fire, btn_open_sel, btn_open_q;
    logic [N_OBJ-1:0] req_open, req_close, busy;
    logic [N_OBJ-1:0] src_open, src_close;

    assign pass_ok = ctrl_q[CTRL_PASS_OK];
    assign btn_obj = N_OBJ'(1) << ctrl_q[CTRL_BTN_OBJ +: CTRL_BTN_OBJ_W];

    // Selective mode: a button press only arms; confirm from the panel fires
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            btn_open_q <= 1'b0;
            sel_q <= '0;
        end else if (pass_ok && !ctrl_q[CTRL_BTN_DIRECT] &&
                     (rise_close_btn || rise_trip_btn)) begin
            btn_open_q <= rise_trip_btn;
            sel_q <= btn_obj;
        end else if (panel_cmd[CMD_CONFIRM] || btn_fire) begin
            sel_q <= '0;
        end
    end

    assign btn_fire = pass_ok && !remote_mode &&
        (ctrl_q[CTRL_BTN_DIRECT] ? (rise_close_btn || rise_trip_btn)
                                 : (panel_cmd[CMD_CONFIRM] && |sel_q));
    assign btn_open_sel = ctrl_q[CTRL_BTN_DIRECT] ? rise_trip_btn
                                                  : btn_open_q;

    assign src_open = (remote_mode ? (re_ro | proto_cmd[N_OBJ-1:0])
                                   : (re_lo | panel_cmd[N_OBJ-1:0]))
        | ((btn_fire && btn_open_sel) ? btn_obj : '0);
    assign src_close = (remote_mode
            ? (re_rc | proto_cmd[CMD_CLOSE +: N_OBJ])
            : (re_lc | panel_cmd[CMD_CLOSE +: N_OBJ]))
        | ((btn_fire && !btn_open_sel) ? btn_obj : '0);
    assign req_open = src_open & ~busy;
    assign req_close = src_close & ~busy & ~src_open;

    // Virtual inputs follow the same gate unless the check is disabled
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            vi_q <= '0;
        end else if (panel_cmd[CMD_VI +: N_OBJ] != '0 &&
                     (!remote_mode || ctrl_q[CTRL_VI_NOCHECK])) begin
            vi_q <= vi_q ^ panel_cmd[CMD_VI +: N_OBJ];
        end else if (proto_cmd[CMD_VI +: N_OBJ] != '0 &&
                     (remote_mode || ctrl_q[CTRL_VI_NOCHECK])) begin
            vi_q <= vi_q ^ proto_cmd[CMD_VI +: N_OBJ];
        end
    end

    // ****************************************************************
    // Per-object pulse engine
    // ****************************************************************
    function automatic sgc_state_e decode(input logic op, input logic cl);
        return sgc_state_e'({cl, op});
    endfunction

    sgc_state_e st_q [N_OBJ];
    sgc_state_e st_now [N_OBJ];
    logic [TIME_W-1:0] pcnt_q [N_OBJ];
    logic [TIME_W-1:0] rcnt_q [N_OBJ];
    logic [N_OBJ-1:0] wait_rdy_q;

    for (genvar g = 0; g < N_OBJ; g++) begin : g_obj
        assign st_now[g] = decode(fb_open[g], fb_close[g]);
        assign busy[g] = o_cmd[g].open_cmd | o_cmd[g].close_cmd;

        always_ff @(posedge i_clk) begin
            if (i_reset) begin
                st_q[g] <= SGC_UNDEF00;
            end else begin
                st_q[g] <= st_now[g];
            end
        end

        always_ff @(posedge i_clk) begin
            if (i_reset) begin
                o_cmd[g] <= '0;
                pcnt_q[g] <= '0;
                o_fail[g] <= 1'b0;
                o_undef_event[g] <= 1'b0;
            end else begin
                o_undef_event[g] <= 1'b0;
                if (req_open[g] || req_close[g]) begin
                    o_cmd[g].open_cmd <= req_open[g];
                    o_cmd[g].close_cmd <= req_close[g];
                    pcnt_q[g] <= '0;
                    // A ready timeout on this same edge still reports
                    o_fail[g] <= wait_rdy_q[g] && tick &&
                        (rcnt_q[g] + 16'h0001 >= ready_to_q);
                end else if (busy[g] && st_now[g] != st_q[g]) begin
                    o_cmd[g] <= '0;
                end else if (busy[g] && tick) begin
                    if (pcnt_q[g] + 16'h0001 >= pulse_len_q) begin
                        o_cmd[g] <= '0;
                        o_fail[g] <= 1'b1;
                        o_undef_event[g] <= 1'b1;
                    end else begin
                        pcnt_q[g] <= pcnt_q[g] + 16'h0001;
                    end
                end else if (wait_rdy_q[g] && tick &&
                             rcnt_q[g] + 16'h0001 >= ready_to_q) begin
                    o_fail[g] <= 1'b1;
                end
            end
        end

        // Ready wait: only armed when a ready input is assigned
        always_ff @(posedge i_clk) begin
            if (i_reset) begin
                wait_rdy_q[g] <= 1'b0;
                rcnt_q[g] <= '0;
            end else if ((req_open[g] || req_close[g]) && ready_en_q[g]) begin
                wait_rdy_q[g] <= 1'b1;
                rcnt_q[g] <= '0;
            end else if (!ready_en_q[g] || fb_ready[g]) begin
                wait_rdy_q[g] <= 1'b0;
            end else if (wait_rdy_q[g] && tick) begin
                if (rcnt_q[g] + 16'h0001 >= ready_to_q) begin
                    wait_rdy_q[g] <= 1'b0;
                end
                rcnt_q[g] <= rcnt_q[g] + 16'h0001;
            end
        end
    end

    // ****************************************************************
    // Latches and release
    // ****************************************************************
    logic release_req;
    logic [TIME_W-1:0] rel_cnt_q;
    assign release_req = (rise_fb1 ||
        (panel_cmd[CMD_RELEASE] && pass_ok) || proto_cmd[CMD_RELEASE]);

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_latch_release <= 1'b0;
            rel_cnt_q <= '0;
        end else if (release_req && |o_latched) begin
            o_latch_release <= 1'b1;
            rel_cnt_q <= '0;
        end else if (o_latch_release && tick) begin
            if (rel_cnt_q + 16'h0001 >= release_len_q) begin
                o_latch_release <= 1'b0;
            end
            rel_cnt_q <= rel_cnt_q + 16'h0001;
        end
    end

    // Set wins over the release so a fresh event is never lost
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_latched <= '0;
        end else begin
            o_latched <= (o_latched & ~{N_OBJ{o_latch_release}})
                | i_latch_set;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_remote <= 1'b0;
            o_vi <= '0;
        end else begin
            o_remote <= remote_mode;
            o_vi <= vi_q;
        end
    end

    // ****************************************************************
    // Read path
    // ****************************************************************
    logic [2*N_OBJ-1:0] st_flat;
    always_comb begin
        st_flat = '0;
        for (int k = 0; k < N_OBJ; k++) begin
            st_flat[2*k +: 2] = st_q[k];
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_rdata <= '0;
        end else if (i_rd) begin
            if (i_addr == REG_CTRL) begin
                o_rdata <= ctrl_q;
            end else if (i_addr == REG_PULSE) begin
                o_rdata <= 32'(pulse_len_q);
            end else if (i_addr == REG_READY) begin
                o_rdata <= 32'(ready_to_q);
            end else if (i_addr == REG_RELEASE) begin
                o_rdata <= 32'(release_len_q);
            end else if (i_addr == REG_STATUS) begin
                o_rdata <= {16'h0000, o_latched, busy};
            end else if (i_addr == REG_FAIL) begin
                o_rdata <= 32'(o_fail);
            end else if (i_addr == REG_STATE) begin
                o_rdata <= 32'(st_flat);
            end else if (i_addr == REG_READY_EN) begin
                o_rdata <= 32'(ready_en_q);
            end else begin
                o_rdata <= '0;
            end
        end else begin
            o_rdata <= '0;
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    release_gate_a: assert property (@(posedge i_clk)
        disable iff (i_reset)
        $rose(o_latch_release) |-> $past(|o_latched))
        else $error("release without latched output");
    for (genvar a = 0; a < N_OBJ; a++) begin : g_chk
        timeout_fail_a: assert property (@(posedge i_clk)
            disable iff (i_reset)
            o_undef_event[a] |-> o_fail[a] && !busy[a])
            else $error("event without failure");
        one_dir_a: assert property (@(posedge i_clk)
            disable iff (i_reset)
            !(o_cmd[a].open_cmd && o_cmd[a].close_cmd))
            else $error("open and close at once");
        busy_hold_a: assert property (@(posedge i_clk)
            disable iff (i_reset)
            (busy[a] && (src_open[a] || src_close[a]))
            |=> ($stable(o_cmd[a]) || !busy[a]))
            else $error("request taken while busy");
        stop_change_a: assert property (@(posedge i_clk)
            disable iff (i_reset)
            (busy[a] && st_now[a] != st_q[a] && !req_open[a] && !req_close[a])
            |=> !busy[a])
            else $error("pulse did not stop on state change");
        latch_hold_a: assert property (@(posedge i_clk)
            disable iff (i_reset)
            (o_latched[a] && !o_latch_release) |=> o_latched[a])
            else $error("latch dropped without release");
        local_ignore_a: assert property (@(posedge i_clk)
            disable iff (i_reset)
            (!remote_mode && !re_lo[a] && !panel_cmd[a] && !btn_fire)
            |-> !src_open[a])
            else $error("remote open acted in local state");
        edge_only_a: assert property (@(posedge i_clk)
            disable iff (i_reset)
            (s2_q[SW-4*N_OBJ+a] && s3_q[SW-4*N_OBJ+a]) |-> !re_ro[a])
            else $error("level triggered command");
    end

endmodule // sgc_object_ctrl

// >>> sgc_pkg.sv
package sgc_pkg;

    // ****************************************************************
    // Clock and timebase
    // ****************************************************************
    localparam int unsigned CLK_HZ = 25_000_000;
    localparam int unsigned TICK_MS = 10;
    localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;

    // ****************************************************************
    // Timing settings, in ms (_MS) and in ticks of TICK_MS
    // ****************************************************************
    localparam int unsigned PULSE_MIN_MS = 20;
    localparam int unsigned PULSE_MAX_MS = 600_000;
    localparam int unsigned PULSE_MIN_TICKS = (PULSE_MIN_MS + TICK_MS - 1) / TICK_MS;
    localparam int unsigned PULSE_MAX_TICKS = PULSE_MAX_MS / TICK_MS;
    localparam int unsigned RELEASE_MS = 1000;
    localparam int unsigned RELEASE_TICKS = RELEASE_MS / TICK_MS;
    localparam int unsigned TIME_W = 16;
    localparam logic [TIME_W-1:0] PULSE_RST = 16'h0064;
    localparam logic [TIME_W-1:0] READY_RST = 16'h0064;
    localparam logic [TIME_W-1:0] RELEASE_RST = 16'h0064;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam int unsigned ADDR_W = 8;
    localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] REG_PULSE = 8'h04;
    localparam logic [ADDR_W-1:0] REG_READY = 8'h08;
    localparam logic [ADDR_W-1:0] REG_RELEASE = 8'h0c;
    localparam logic [ADDR_W-1:0] REG_PANEL_CMD = 8'h10;
    localparam logic [ADDR_W-1:0] REG_PROTO_CMD = 8'h14;
    localparam logic [ADDR_W-1:0] REG_STATUS = 8'h18;
    localparam logic [ADDR_W-1:0] REG_FAIL = 8'h1c;
    localparam logic [ADDR_W-1:0] REG_STATE = 8'h20;
    localparam logic [ADDR_W-1:0] REG_READY_EN = 8'h24;

    // REG_CTRL fields
    localparam int unsigned CTRL_LR_SRC = 0;
    localparam int unsigned CTRL_PANEL_REMOTE = 1;
    localparam int unsigned CTRL_VI_NOCHECK = 2;
    localparam int unsigned CTRL_BTN_DIRECT = 3;
    localparam int unsigned CTRL_PASS_OK = 4;
    localparam int unsigned CTRL_BTN_OBJ = 8;
    localparam int unsigned CTRL_BTN_OBJ_W = 3;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;

    // Command register fields: [7:0] open, [15:8] close
    localparam int unsigned CMD_CLOSE = 8;
    localparam int unsigned CMD_RELEASE = 16;
    localparam int unsigned CMD_SELECT = 17;
    localparam int unsigned CMD_CONFIRM = 18;
    localparam int unsigned CMD_VI = 24;

    // ****************************************************************
    // Object state codes
    // ****************************************************************
    typedef enum logic [1:0] {
        SGC_UNDEF00 = 2'h0,
        SGC_OPEN = 2'h1,
        SGC_CLOSE = 2'h2,
        SGC_UNDEF11 = 2'h3
    } sgc_state_e;

    typedef struct packed {
        logic open_cmd;
        logic close_cmd;
    } sgc_cmd_s;

endpackage

// >>> sgc_switch_model.sv
`timescale 1ns/1ns
module sgc_switch_model
    import sgc_pkg::*;
#(
    parameter int unsigned DLY = 3
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire sgc_cmd_s [7:0] i_cmd,
    input wire logic [7:0] i_stuck,
    output logic [7:0] o_open_fb,
    output logic [7:0] o_close_fb,
    output logic [7:0] o_ready_fb
);
    int cnt [8];
    // A stuck mechanism never moves, which is how the timeout is provoked
    always @(posedge i_clk) begin
        for (int i = 0; i < 8; i++) begin
            if (i_reset) begin
                o_open_fb[i] <= 1'b0;
                o_close_fb[i] <= 1'b1;
                cnt[i] = 0;
            end else if ((i_cmd[i] != 2'h0) && !i_stuck[i]) begin
                cnt[i] = cnt[i] + 1;
                if (cnt[i] == DLY) begin
                    o_open_fb[i] <= i_cmd[i].open_cmd;
                    o_close_fb[i] <= !i_cmd[i].open_cmd;
                end
            end else begin
                cnt[i] = 0;
            end
        end
    end
    assign o_ready_fb = o_open_fb ^ o_close_fb;
endmodule // sgc_switch_model

// >>> tb.sv
`timescale 1ns/1ns
module tb;
    import sgc_pkg::*;
    logic i_clk = 1'b0, i_reset = 1'b1, i_wr = 1'b0, i_rd = 1'b0;
    logic [ADDR_W-1:0] i_addr = 8'h00;
    logic [31:0] i_wdata = 32'h0, o_rdata, rv;
    logic [7:0] ofb, cfb, rfb, stuck = 8'h00, ev_seen = 8'h00;
    logic [7:0] r_open = 8'h0, r_close = 8'h0, l_open = 8'h0, l_close = 8'h0;
    logic [7:0] latch_set = 8'h0, o_fail, o_undef_event, o_latched, o_vi;
    logic o_latch_release, o_remote;
    logic lr = 1'b0, cbtn = 1'b0, tbtn = 1'b0, f1 = 1'b0;
    sgc_cmd_s [7:0] o_cmd;
    logic [15:0] exp_st = 16'haaaa;
    int err_total = 0, total_checks = 0, seed = 8, k, n;
    always #20 i_clk = ~i_clk;
    sgc_object_ctrl #(.N_OBJ(8), .TICK_DIV(4)) u_sgc_object_ctrl (
        .i_clk(i_clk), .i_reset(i_reset), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_open_feedback_input(ofb), .i_close_feedback_input(cfb),
        .i_ready_feedback_input(rfb), .i_remote_open(r_open),
        .i_remote_close(r_close), .i_local_open(l_open),
        .i_local_close(l_close), .i_lr_input(lr), .i_close_button(cbtn),
        .i_trip_button(tbtn), .i_function_button_one(f1),
        .i_latch_set(latch_set), .o_cmd(o_cmd), .o_fail(o_fail),
        .o_undef_event(o_undef_event), .o_latched(o_latched),
        .o_latch_release(o_latch_release), .o_remote(o_remote), .o_vi(o_vi)
    );
    sgc_switch_model #(.DLY(3)) u_sgc_switch_model (
        .i_clk(i_clk), .i_reset(i_reset), .i_cmd(o_cmd), .i_stuck(stuck),
        .o_open_fb(ofb), .o_close_fb(cfb), .o_ready_fb(rfb)
    );
    // Event is one cycle wide, so keep a sticky copy
    always @(posedge i_clk) begin
        ev_seen <= ev_seen | o_undef_event;
    end
    // ****************************************************************
    // Bench tasks
    // ****************************************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge i_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 rv = o_rdata;
    endtask
    // Bounded wait on the running/idle state of one object's command
    task automatic wait_cmd(input logic v, input int lim);
        n = 0;
        while (((o_cmd[k].open_cmd | o_cmd[k].close_cmd) !== v) && n < lim) begin
            @(negedge i_clk);
            n++;
        end
    endtask
    function automatic logic [15:0] put(input logic [15:0] s, input int i,
        input sgc_state_e v);
        s[2*i +: 2] = v;
        return s;
    endfunction
    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        #800000;
        err_total++;
        close_out;
    end
    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        k = $unsigned($random(seed)) % 8;
        repeat (20) @(posedge i_clk);
        i_reset <= 1'b0;
        repeat (5) @(posedge i_clk);
        rd(REG_CTRL); chk(rv, CTRL_RST);
        rd(REG_PULSE); chk(rv, {16'h0, PULSE_RST});
        rd(8'hfc); chk(rv, 32'h0);
        wr(REG_READY_EN, 32'hff);
        rd(REG_READY_EN); chk(rv, 32'hff);
        rd(REG_STATE); chk(rv, {16'h0, exp_st});
        wr(REG_PULSE, 32'h5);
        wr(REG_CTRL, 32'h1 << CTRL_PANEL_REMOTE);
        repeat (3) @(posedge i_clk);
        chk(o_remote, 1'b1);
        wr(REG_PROTO_CMD, 32'h1 << k);
        wait_cmd(1'b1, 4); chk(o_cmd[k].open_cmd, 1'b1);
        wait_cmd(1'b0, 12); chk(o_cmd[k], 2'h0);
        exp_st = put(exp_st, k, SGC_OPEN);
        rd(REG_STATE); chk(rv, {16'h0, exp_st});
        $display("remote open test done");
        wr(REG_CTRL, 32'h0);
        wr(REG_PROTO_CMD, (32'h1 << (CMD_CLOSE + k)) |
            (32'h1 << (CMD_VI + k)));
        wr(REG_PANEL_CMD, 32'h1 << (CMD_VI + k));
        repeat (6) @(posedge i_clk);
        chk(o_cmd[k], 2'h0);
        chk(o_vi, 32'h1 << k);
        r_close[k] <= 1'b1;
        repeat (8) @(posedge i_clk);
        chk(o_cmd[k], 2'h0);
        r_close[k] <= 1'b0;
        l_close[k] <= 1'b1;
        wait_cmd(1'b1, 8); chk(o_cmd[k].close_cmd, 1'b1);
        wait_cmd(1'b0, 12);
        repeat (24) @(posedge i_clk);
        chk(o_cmd[k], 2'h0);
        l_close[k] <= 1'b0;
        exp_st = put(exp_st, k, SGC_CLOSE);
        rd(REG_STATE); chk(rv, {16'h0, exp_st});
        $display("local gating test done");
        stuck[k] <= 1'b1;
        wr(REG_CTRL, 32'h1 << CTRL_PANEL_REMOTE);
        wr(REG_PROTO_CMD, 32'h1 << k);
        wait_cmd(1'b1, 4);
        wr(REG_PROTO_CMD, 32'h1 << (CMD_CLOSE + k));
        @(negedge i_clk);
        chk(o_cmd[k], 2'h2);
        repeat (12) @(posedge i_clk);
        chk(o_fail[k], 1'b0);
        wait_cmd(1'b0, 30); chk(o_cmd[k], 2'h0);
        repeat (2) @(posedge i_clk);
        chk(o_fail[k], 1'b1);
        chk(ev_seen[k], 1'b1);
        stuck[k] <= 1'b0;
        $display("timeout test done");
        wr(REG_CTRL, (32'h1 << CTRL_PASS_OK) | (32'h1 << CTRL_BTN_DIRECT)
            | (k << CTRL_BTN_OBJ));
        tbtn <= 1'b1;
        wait_cmd(1'b1, 8); chk(o_cmd[k], 2'h2);
        chk(o_fail[k], 1'b0);
        wait_cmd(1'b0, 12);
        @(posedge i_clk);
        tbtn <= 1'b0;
        wr(REG_CTRL, (32'h1 << CTRL_PASS_OK) | (k << CTRL_BTN_OBJ));
        cbtn <= 1'b1;
        repeat (6) @(posedge i_clk);
        chk(o_cmd[k], 2'h0);
        wr(REG_PANEL_CMD, 32'h1 << CMD_CONFIRM);
        @(negedge i_clk);
        chk(o_cmd[k], 2'h1);
        wait_cmd(1'b0, 12);
        @(posedge i_clk);
        cbtn <= 1'b0;
        wr(REG_CTRL, 32'h1 << CTRL_LR_SRC);
        lr <= 1'b1;
        repeat (4) @(posedge i_clk);
        chk(o_remote, 1'b1);
        $display("button test done");
        wr(REG_RELEASE, 32'h2);
        f1 <= 1'b1;
        repeat (5) @(posedge i_clk);
        chk(o_latch_release, 1'b0);
        f1 <= 1'b0;
        latch_set[k] <= 1'b1;
        repeat (3) @(posedge i_clk);
        latch_set[k] <= 1'b0;
        repeat (3) @(posedge i_clk);
        chk(o_latched[k], 1'b1);
        wr(REG_PROTO_CMD, 32'h1 << CMD_RELEASE);
        repeat (4) @(posedge i_clk);
        chk(o_latched, 8'h0);
        repeat (8) @(posedge i_clk);
        chk(o_latch_release, 1'b0);
        $display("latch test done");
        close_out;
    end
endmodule // tb
